// ===== logic/vsp_video_port.sv
// Pixel port of the sensor: FIFO, sync shaping and the APB register file.
// Assumes link_clk is a free clock from outside, far slower than clock.
//
// Notes on behaviour
// - Config bit 6 set gates pixel clock to data-ready; clear runs it free.
// - Config bit 5 set makes frame sync a pulse; clear makes it a level.
// - Bit 4 set pulses line sync four pixel clocks at row end; clear is level.
// - Frame polarity set: high level in frame, low end pulse; clear inverts both.
// - Line polarity set: high level in row, low end pulse; clear inverts both.
// - Level line sync spans the row; pulse line sync lasts four clocks after.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns

module vsp_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Honest flags from the word count
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_reg];

  // Storage, written only on an accepted push
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap naturally only when DEPTH is a power of two
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end
endmodule

module vsp_video_port
  import vsp_pkg::*;
#(
  parameter int DATA_W = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pixel stream from the readout chain
  input wire logic [DATA_W-1:0] pix_in,
  input wire logic pix_in_eol,
  input wire logic pix_in_eof,
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  // Link timing input
  input wire logic link_clk,
  // Video port pins
  output logic pclk_out,
  output logic line_sync_out,
  output logic frame_sync_out,
  output logic [DATA_W-1:0] pix_out,
  output logic port_oe_n
);
  import vsp_pkg::*;

  localparam int FW = DATA_W + 2;

  logic [7:0] cfg_reg;
  logic [7:0] adj_reg;
  logic link_meta_reg;
  logic link_s_reg;
  logic link_d_reg;
  logic link_rise;
  logic link_fall;
  logic [FW-1:0] fifo_out;
  logic fifo_valid;
  logic fifo_pop;
  logic row_end;
  vsp_state_t st_reg;
  logic shown_reg;
  logic last_eol_reg;
  logic last_eof_reg;
  logic [2:0] lcnt_reg;
  logic [2:0] fcnt_reg;
  logic pclk_reg;
  logic line_sync_reg;
  logic frame_sync_reg;
  logic [DATA_W-1:0] pix_out_reg;
  logic pixel_clock_gating_select;
  logic frame_sync_style_select;
  logic line_sync_style_select;
  logic frame_sync_polarity;
  logic line_sync_polarity;
  logic apb_wr;
  logic [7:0] stat_word;

  // Named views of the configuration fields
  assign pixel_clock_gating_select = cfg_reg[VSP_PCLK_GATE_BIT];
  assign frame_sync_style_select = cfg_reg[VSP_FSTYLE_BIT];
  assign line_sync_style_select = cfg_reg[VSP_LSTYLE_BIT];
  assign frame_sync_polarity = cfg_reg[VSP_FPOL_BIT];
  assign line_sync_polarity = cfg_reg[VSP_LPOL_BIT];

  // APB: zero wait states, error on unmapped addresses
  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;
  assign stat_word = {5'h00, ~pix_in_ready, st_reg == VSP_ST_ROW, st_reg != VSP_ST_IDLE};

  // Read mux and error answer for the access phase
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        VSP_CFG_ADDR: prdata = {24'h00_0000, cfg_reg};
        VSP_ADJ_ADDR: prdata = {24'h00_0000, adj_reg};
        VSP_STAT_ADDR: prdata = {24'h00_0000, stat_word};
        default: pslverr = 1'b1;
      endcase
    end
  end

  // Config register; reserved bits keep their reset pattern
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_reg <= VSP_CFG_RST;
    end else if (apb_wr && paddr == VSP_CFG_ADDR) begin
      cfg_reg <= (pwdata[7:0] & VSP_CFG_WMASK) | (VSP_CFG_RST & ~VSP_CFG_WMASK);
    end
  end

  // Output adjust register; only its enable bit steers this block
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      adj_reg <= VSP_ADJ_RST;
    end else if (apb_wr && paddr == VSP_ADJ_ADDR) begin
      adj_reg <= pwdata[7:0];
    end
  end

  // Two-flop synchroniser, then a third flop for edge finding
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link_meta_reg <= 1'b0;
      link_s_reg <= 1'b0;
      link_d_reg <= 1'b0;
    end else begin
      link_meta_reg <= link_clk;
      link_s_reg <= link_meta_reg;
      link_d_reg <= link_s_reg;
    end
  end

  assign link_rise = link_s_reg & ~link_d_reg;
  assign link_fall = ~link_s_reg & link_d_reg;

  // Staging FIFO; a full FIFO stalls the readout chain
  vsp_fifo #(
    .W(FW),
    .DEPTH(VSP_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_data({pix_in_eof, pix_in_eol, pix_in}),
    .in_valid(pix_in_valid),
    .in_ready(pix_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // A row closes on the first link rise after its last word was shown.
  // No word is taken on that rise, so level line sync always leaves its active level between rows.
  assign row_end = link_rise & shown_reg & last_eol_reg;
  assign fifo_pop = link_rise & fifo_valid & ~row_end;

  // Row and frame sequencer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= VSP_ST_IDLE;
    end else if (fifo_pop) begin
      st_reg <= VSP_ST_ROW;
    end else if (row_end) begin
      case (st_reg)
        VSP_ST_ROW: st_reg <= last_eof_reg ? VSP_ST_IDLE : VSP_ST_GAP;
        default: st_reg <= st_reg;
      endcase
    end
  end

  // Word presentation; an underflow mid-row leaves shown_reg low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      shown_reg <= 1'b0;
      last_eol_reg <= 1'b0;
      last_eof_reg <= 1'b0;
      pix_out_reg <= '0;
    end else if (link_rise) begin
      shown_reg <= fifo_pop;
      if (fifo_pop) begin
        pix_out_reg <= fifo_out[DATA_W-1:0];
        last_eol_reg <= fifo_out[DATA_W];
        last_eof_reg <= fifo_out[DATA_W+1];
      end
    end
  end

  // Line pulse length, counted in pixel clock periods
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lcnt_reg <= 3'h0;
    end else if (row_end) begin
      lcnt_reg <= VSP_LINE_PULSE_CLKS;
    end else if (link_rise && lcnt_reg != 3'h0) begin
      lcnt_reg <= lcnt_reg - 3'h1;
    end
  end

  // Frame pulse length, loaded only when the closing row ends the frame
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fcnt_reg <= 3'h0;
    end else if (row_end && last_eof_reg) begin
      fcnt_reg <= VSP_FRAME_PULSE_CLKS;
    end else if (link_rise && fcnt_reg != 3'h0) begin
      fcnt_reg <= fcnt_reg - 3'h1;
    end
  end

  // Pixel clock: low on link high so data settle before the rising pin edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pclk_reg <= 1'b0;
    end else begin
      pclk_reg <= ~link_s_reg & (~pixel_clock_gating_select | shown_reg);
    end
  end

  // Line sync shaping: style picks pulse or level, polarity flips either
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      line_sync_reg <= 1'b0;
    end else if (line_sync_style_select) begin
      line_sync_reg <= (lcnt_reg != 3'h0) ^ line_sync_polarity;
    end else begin
      line_sync_reg <= (st_reg == VSP_ST_ROW) ^ ~line_sync_polarity;
    end
  end

  // Frame sync shaping; style picks pulse or level, polarity flips either
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_sync_reg <= 1'b0;
    end else if (frame_sync_style_select) begin
      frame_sync_reg <= (fcnt_reg != 3'h0) ^ frame_sync_polarity;
    end else begin
      frame_sync_reg <= (st_reg != VSP_ST_IDLE) ^ ~frame_sync_polarity;
    end
  end

  // Pins; enable is shared by data and control, low means driving
  assign pclk_out = pclk_reg;
  assign line_sync_out = line_sync_reg;
  assign frame_sync_out = frame_sync_reg;
  assign pix_out = pix_out_reg;
  assign port_oe_n = ~adj_reg[VSP_ADJ_OE_BIT];

  // Checks on the shaped outputs and the line pulse counter
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  property p_free_clock;
    !pixel_clock_gating_select && link_fall ##1 !pixel_clock_gating_select |=> pclk_reg;
  endproperty
  a_free_clock: assert property (p_free_clock)
    else $error("free running pixel clock missed a high phase");

  property p_gated_clock;
    pixel_clock_gating_select && !shown_reg && $stable(cfg_reg) |=> !pclk_reg;
  endproperty
  a_gated_clock: assert property (p_gated_clock)
    else $error("gated pixel clock toggled without a word");

  property p_frame_pulse;
    frame_sync_style_select && fcnt_reg != 3'h0 && $stable(cfg_reg)
      |=> frame_sync_reg == !frame_sync_polarity;
  endproperty
  a_frame_pulse: assert property (p_frame_pulse)
    else $error("frame pulse level wrong");

  property p_line_load;
    st_reg == VSP_ST_ROW && row_end |=> lcnt_reg == VSP_LINE_PULSE_CLKS && st_reg != VSP_ST_ROW;
  endproperty
  a_line_load: assert property (p_line_load)
    else $error("line pulse not loaded at row end");

  property p_frame_level;
    !frame_sync_style_select && st_reg != VSP_ST_IDLE && $stable(cfg_reg)
      |=> frame_sync_reg == frame_sync_polarity;
  endproperty
  a_frame_level: assert property (p_frame_level)
    else $error("frame level polarity wrong");

  property p_line_level;
    !line_sync_style_select && st_reg == VSP_ST_ROW && $stable(cfg_reg)
      |=> line_sync_reg == line_sync_polarity;
  endproperty
  a_line_level: assert property (p_line_level)
    else $error("line level polarity wrong");

  property p_line_hold;
    lcnt_reg != 3'h0 && !link_rise && !row_end |=> lcnt_reg == $past(lcnt_reg);
  endproperty
  a_line_hold: assert property (p_line_hold)
    else $error("line pulse counted off a link edge");
endmodule

// ===== inc/vsp_pkg.sv
// Constants for the video sync polarity and mode block.
// Assumes a 12-bit APB byte address; registers sit at four times their index.
package vsp_pkg;
  // Register indexes and byte addresses
  localparam logic [7:0] VSP_CFG_IDX = 8'h53;
  localparam logic [7:0] VSP_ADJ_IDX = 8'h54;
  localparam logic [7:0] VSP_STAT_IDX = 8'h55;
  localparam logic [11:0] VSP_CFG_ADDR = {2'b00, VSP_CFG_IDX, 2'b00};
  localparam logic [11:0] VSP_ADJ_ADDR = {2'b00, VSP_ADJ_IDX, 2'b00};
  localparam logic [11:0] VSP_STAT_ADDR = {2'b00, VSP_STAT_IDX, 2'b00};
  // Reset values and writable bits
  localparam logic [7:0] VSP_CFG_RST = 8'h0C;
  localparam logic [7:0] VSP_CFG_WMASK = 8'h73;
  localparam logic [7:0] VSP_ADJ_RST = 8'hF0;
  // Field positions in sync_polarity_mode_config
  localparam int VSP_PCLK_GATE_BIT = 6;
  localparam int VSP_FSTYLE_BIT = 5;
  localparam int VSP_LSTYLE_BIT = 4;
  localparam int VSP_FPOL_BIT = 1;
  localparam int VSP_LPOL_BIT = 0;
  // Field position in video_output_adjust
  localparam int VSP_ADJ_OE_BIT = 7;
  // Pulse lengths in pixel clock periods
  localparam logic [2:0] VSP_LINE_PULSE_CLKS = 3'h4;
  localparam logic [2:0] VSP_FRAME_PULSE_CLKS = 3'h4;
  // FIFO depth in words
  localparam int VSP_FIFO_DEPTH = 16;
  // Output sequencer states, Gray coded along idle -> row -> gap -> row
  typedef enum logic [1:0] {
    VSP_ST_IDLE = 2'b00,
    VSP_ST_ROW = 2'b01,
    VSP_ST_GAP = 2'b11
  } vsp_state_t;
endpackage

// ===== sim/vsp_host_model.sv
// Host side of the video port: logs each pixel word on a pixel clock rise.
// Assumes the pins are driven while it listens; it drives nothing back.
`timescale 1ns/1ns
module vsp_host_model #(
  parameter int W = 10
) (
  // Video port pins
  input wire logic pclk,
  input wire logic [W-1:0] pix,
  // Log clear from the bench
  input wire logic clr
);
  logic [W-1:0] got[$];
  int rises;

  // Sample on the rise, because the port moves data while the clock is low
  always @(posedge pclk or posedge clr) begin
    if (clr) begin
      got.delete();
      rises = 0;
    end else begin
      got.push_back(pix);
      rises++;
    end
  end
endmodule

// ===== sim/tb_vsp_video_port.sv
// Bench for the video port: APB set-up, frames in, host log and sync widths out.
// Assumes a free 400 ns link clock and one frame in flight at a time.
`timescale 1ns/1ns
module tb_vsp_video_port;
  import vsp_pkg::*;
  localparam int LINK_CLKS = 8;
  logic clock, sys_rst, psel, penable, pwrite, pix_in_eol, pix_in_eof, pix_in_valid;
  logic link_clk, clr, meas, full_seen, lact, fact, err, pready, pslverr, pix_in_ready;
  logic pclk_out, line_sync_out, frame_sync_out, port_oe_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rs;
  logic [9:0] pix_in, pix_out;
  logic [9:0] sent[$];
  logic [7:0] cfgs[5];
  int miscompares, compares, lcnt, fcnt, n, r;

  vsp_video_port #(.DATA_W(10)) i_vsp_video_port (.clock(clock), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_in(pix_in),
    .pix_in_eol(pix_in_eol), .pix_in_eof(pix_in_eof), .pix_in_valid(pix_in_valid),
    .pix_in_ready(pix_in_ready), .link_clk(link_clk), .pclk_out(pclk_out),
    .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out), .pix_out(pix_out),
    .port_oe_n(port_oe_n));
  vsp_host_model #(.W(10)) i_vsp_host_model (.pclk(pclk_out), .pix(pix_out), .clr(clr));

  // Clocks; the link starts off phase so its edges keep a fixed offset from the system clock
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  initial begin
    link_clk = 0;
    #137;
    forever #200 link_clk = ~link_clk;
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Active sync cycles expected over one frame of r rows of n words
  function automatic int exp_line(logic [7:0] c, int n, int r);
    return c[VSP_LSTYLE_BIT] ? int'(VSP_LINE_PULSE_CLKS) * LINK_CLKS * r : LINK_CLKS * n * r;
  endfunction
  function automatic int exp_frame(logic [7:0] c, int n, int r);
    return c[VSP_FSTYLE_BIT] ? int'(VSP_FRAME_PULSE_CLKS) * LINK_CLKS
                             : LINK_CLKS * (r * (n + 1) - 1);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // One APB transfer, then an idle edge so psel is never set twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic send_frame(input int n, input int r);
    logic [9:0] d;
    for (int j = 0; j < r; j++) begin
      for (int i = 0; i < n; i++) begin
        d = 10'(xs());
        sent.push_back(d);
        pix_in <= d;
        pix_in_valid <= 1'b1;
        pix_in_eol <= (i == n - 1);
        pix_in_eof <= (i == n - 1) && (j == r - 1);
        @(posedge clock);
        while (pix_in_ready !== 1'b1) @(posedge clock);
      end
    end
    pix_in_valid <= 1'b0;
  endtask

  // Active level: the polarity bit for a level, its inverse for a pulse
  task automatic run(input logic [7:0] c, input int n, input int r);
    apb(1'b1, VSP_CFG_ADDR, {24'h0, c});
    lact = c[VSP_LSTYLE_BIT] ^ c[VSP_LPOL_BIT];
    fact = c[VSP_FSTYLE_BIT] ^ c[VSP_FPOL_BIT];
    sent.delete();
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    meas <= 1'b1;
    send_frame(n, r);
    repeat ((r * (n + 1) + 10) * LINK_CLKS) @(posedge clock);
    meas <= 1'b0;
    chk(lcnt, exp_line(c, n, r));
    chk(fcnt, exp_frame(c, n, r));
    if (c[VSP_PCLK_GATE_BIT]) begin
      chk(i_vsp_host_model.rises, sent.size());
      foreach (sent[i]) chk(i_vsp_host_model.got[i], sent[i]);
    end else begin
      chk(i_vsp_host_model.rises > sent.size(), 1);
    end
    if (n > VSP_FIFO_DEPTH) chk(full_seen, 1);
  endtask

  // Counted on the falling edge, where the registered pins have settled
  always @(negedge clock) begin
    if (!meas) begin
      lcnt = 0;
      fcnt = 0;
      full_seen = 0;
    end else begin
      lcnt += (line_sync_out === lact);
      fcnt += (frame_sync_out === fact);
      if (pix_in_ready === 1'b0) full_seen = 1;
    end
  end

  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog far beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end

  initial begin
    rs = 32'h41;
    {sys_rst, psel, penable, pwrite, clr, meas} = 6'h20;
    {pix_in_eol, pix_in_eof, pix_in_valid, paddr, pwdata, pix_in} = '0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, VSP_CFG_ADDR, 32'h0);
    chk(rd, 32'(VSP_CFG_RST));
    apb(1'b0, VSP_ADJ_ADDR, 32'h0);
    chk(rd, 32'(VSP_ADJ_RST));
    // Idle port: no frame, no row, FIFO not full
    apb(1'b0, VSP_STAT_ADDR, 32'h0);
    chk(rd, 0);
    chk(err, 0);
    apb(1'b1, VSP_CFG_ADDR, 32'hFF);
    apb(1'b0, VSP_CFG_ADDR, 32'h0);
    chk(rd, 32'((8'hFF & VSP_CFG_WMASK) | VSP_CFG_RST));
    apb(1'b0, 12'h000, 32'h0);
    chk(err, 1);
    chk(rd, 0);
    apb(1'b1, VSP_ADJ_ADDR, 32'h70);
    chk(port_oe_n, 1);
    apb(1'b1, VSP_ADJ_ADDR, 32'hF0);
    chk(port_oe_n, 0);
    // The last entry fills the FIFO with one row longer than its depth
    cfgs = '{8'h40, 8'h73, 8'h03, 8'h30, 8'h40};
    foreach (cfgs[i]) begin
      n = (i == 4) ? 20 : 3 + int'(xs() % 4);
      r = (i == 4) ? 1 : 2;
      run(cfgs[i], n, r);
    end
    report_and_stop();
  end
endmodule
